/* File: core/uef_params.svh */
// Constants of the event flag, error flag and transaction status block.
// Assumes an 8-bit register port with a 9-bit byte address.
`ifndef UEF_PARAMS_SVH
`define UEF_PARAMS_SVH

// Register port widths
`define UEF_ADDR_W 9
`define UEF_DATA_W 8

// Register offsets
`define UEF_OFS_EVT_FLAGS 9'h190
`define UEF_OFS_EVT_EN 9'h191
`define UEF_OFS_ERR_FLAGS 9'h192
`define UEF_OFS_ERR_EN 9'h193
`define UEF_OFS_XSTAT 9'h194
`define UEF_OFS_CTRL 9'h195
`define UEF_OFS_IRQ_STAT 9'h19C
`define UEF_OFS_IRQ_MASK 9'h19D

// Event flag and event enable bit positions
`define UEF_BIT_STALL 5
`define UEF_BIT_IDLE 4
`define UEF_BIT_TOKDN 3
`define UEF_BIT_ACT 2
`define UEF_BIT_ERRSUM 1
`define UEF_BIT_BRST 0
`define UEF_EVT_MASK 8'h3F

// Control register bit positions
`define UEF_BIT_SUSPEND 1

// Block interrupt status bits
`define UEF_IRQ_PUSH 0
`define UEF_IRQ_OVFL 1
`define UEF_IRQ_ERR 2
`define UEF_IRQ_MASK_BITS 8'h07

// Reset values
`define UEF_RST_BYTE 8'h00
`define UEF_RST_EVT_EN 8'h00
`define UEF_RST_ERR_EN 8'h00
`define UEF_RST_CTRL 8'h00

// Status queue: one visible entry plus holding entries
`define UEF_QUEUE_DEPTH 4
`define UEF_HOLD_DEPTH 3
`define UEF_CNT_W 2

`endif

/* File: core/uef_pkg.sv */
// Types shared by the event flag block and its submodules.
// Assumes uef_params.svh supplies the widths.
`include "uef_params.svh"

package uef_pkg;
   typedef logic [`UEF_DATA_W-1:0] uef_byte_t;
   typedef logic [`UEF_ADDR_W-1:0] uef_addr_t;
   typedef logic [`UEF_CNT_W-1:0] uef_cnt_t;
endpackage : uef_pkg

/* File: core/uef_err_flags.sv */
// Error flags, error enables and the combined error summary.
// Assumes detect pulses come from logic on the same clock.
`timescale 1ns/1ps
`include "uef_params.svh"

module uef_err_flags (
   input wire logic core_clk,
   input wire logic rstn,
   input wire uef_pkg::uef_byte_t err_detect,
   input wire logic flags_wr,
   input wire logic en_wr,
   input wire uef_pkg::uef_byte_t wdata,
   output uef_pkg::uef_byte_t err_flags,
   output uef_pkg::uef_byte_t err_en,
   output logic err_summary
);
   import uef_pkg::*;

   uef_byte_t flag_q;
   uef_byte_t en_q;

   // Per-bit sticky flag: detection sets at once, a written zero clears, set wins
   genvar i;
   for (i = 0; i < `UEF_DATA_W; i = i + 1) begin : g_flag
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            flag_q[i] <= 1'b0;
         end else if (err_detect[i]) begin
            flag_q[i] <= 1'b1; // [RULE5]
         end else if (flags_wr && !wdata[i]) begin
            flag_q[i] <= 1'b0; // [RULE6]
         end
      end
   end

   // Error enable register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         en_q <= `UEF_RST_ERR_EN;
      end else if (en_wr) begin
         en_q <= wdata;
      end
   end

   // Bits 7..4: stuffing, ownership, write, turnaround; 3..0: byte count, crc16, crc5, pid
   assign err_summary = |(flag_q & en_q); // [RULE4] [RULE7] [RULE8]
   assign err_flags = flag_q;
   assign err_en = en_q;
endmodule : uef_err_flags

/* File: core/uef_stat_queue.sv */
// Transaction status queue: visible entry, holding entries, token done flag.
// Assumes push and clear requests are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`include "uef_params.svh"

module uef_stat_queue (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic push,
   input wire uef_pkg::uef_byte_t push_data,
   input wire logic clear_req,
   output uef_pkg::uef_byte_t stat,
   output logic tok_done,
   output logic overflow
);
   import uef_pkg::*;

   uef_byte_t stat_q;
   uef_byte_t hold_q [0:`UEF_HOLD_DEPTH-1];
   uef_cnt_t cnt_q;
   logic tok_q;
   logic pop;
   logic have_hold;
   logic hold_push;

   // Clear only counts while the flag is up
   assign pop = clear_req && tok_q;
   assign have_hold = (cnt_q != 2'd0);
   assign hold_push = push && tok_q && !pop && (cnt_q != 2'(`UEF_HOLD_DEPTH));
   assign overflow = push && tok_q && !pop && (cnt_q == 2'(`UEF_HOLD_DEPTH));

   // Visible entry and token done flag
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         stat_q <= `UEF_RST_BYTE;
         tok_q <= 1'b0;
      end else if (pop && have_hold) begin
         stat_q <= hold_q[0]; // [RULE14]
         tok_q <= 1'b1; // [RULE15]
      end else if (pop) begin
         stat_q <= push ? push_data : `UEF_RST_BYTE; // [RULE17]
         tok_q <= push; // [RULE15]
      end else if (push && !tok_q) begin
         stat_q <= push_data; // [RULE11]
         tok_q <= 1'b1; // [RULE17]
      end
   end

   // Holding entries shift toward the visible entry on a pop
   genvar i;
   for (i = 0; i < `UEF_HOLD_DEPTH; i = i + 1) begin : g_hold
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            hold_q[i] <= `UEF_RST_BYTE;
         end else if (pop && have_hold) begin
            if (push && (cnt_q == 2'(i + 1))) begin
               hold_q[i] <= push_data; // [RULE12]
            end else if (i < `UEF_HOLD_DEPTH - 1) begin
               hold_q[i] <= hold_q[(i + 1) % `UEF_HOLD_DEPTH];
            end
         end else if (hold_push && (cnt_q == 2'(i))) begin
            hold_q[i] <= push_data; // [RULE13]
         end
      end
   end

   // Occupancy of the holding entries
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 2'd0;
      end else if (pop && have_hold && !push) begin
         cnt_q <= cnt_q - 2'd1;
      end else if (hold_push) begin
         cnt_q <= cnt_q + 2'd1;
      end
   end

   assign stat = stat_q;
   assign tok_done = tok_q;
endmodule : uef_stat_queue

/* File: core/uef_top.sv */
// Event flags, enables, error summary and transaction status for the USB function.
// Assumes the serial engine, on core_clk, gives one-cycle event pulses
// and a one-cycle buffer descriptor done pulse with its status byte.
// Operation
// (RULE1) Six enable bits 5..0 gate stall, idle, token done, activity, error, reset.
// (RULE2) Event enable bit 1 lets the error summary raise the core interrupt.
// (RULE3) While suspended only the activity event may raise an interrupt; suspend does not gate blk_irq, which block events still raise.
// (RULE4) Error flags ANDed with their enables, ORed into the error summary flag.
// (RULE5) An error flag sets in the cycle its error is detected.
// (RULE6) Error flags stay set until software writes zero to them.
// (RULE7) Error enables 7..4 gate stuffing, ownership, write and turnaround errors.
// (RULE8) Error enables 3..0 gate byte count, crc16, crc5 and pid errors.
// (RULE9) Firmware reads transaction status before clearing token done.
// (RULE10) Transaction status is valid whenever token done is set.
// (RULE11) Each finished buffer descriptor pushes a status entry.
// (RULE12) Transaction status reads a four byte queue.
// (RULE13) Status arriving before token done is serviced waits in the queue.
// (RULE14) Clearing token done loads the next queued status.
// (RULE15) A waiting entry sets token done again at once, otherwise it stays clear.
// (RULE16) Enabled event flags ORed into one interrupt; flags clear on written zero.
// (RULE17) Token done sets at token end; clearing it with nothing queued clears status.
`timescale 1ns/1ps
`include "uef_params.svh"

module uef_top (
   input wire logic core_clk,
   input wire logic rstn,
   input wire uef_pkg::uef_addr_t reg_addr,
   input wire uef_pkg::uef_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output uef_pkg::uef_byte_t reg_rdata,
   input wire logic evt_stall,
   input wire logic evt_idle,
   input wire logic evt_activity,
   input wire logic evt_bus_reset,
   input wire uef_pkg::uef_byte_t err_detect,
   input wire logic bd_done,
   input wire uef_pkg::uef_byte_t bd_status,
   output logic suspend_ctrl,
   output logic usb_irq,
   output logic blk_irq
);
   import uef_pkg::*;

   // Write and read decode
   logic wr_evt_flags;
   logic wr_evt_en;
   logic wr_err_flags;
   logic wr_err_en;
   logic wr_ctrl;
   logic wr_irq_mask;
   logic rd_irq_stat;

   // Register state
   uef_byte_t evt_en_q;
   uef_byte_t ctrl_q;
   uef_byte_t irq_stat_q;
   uef_byte_t irq_mask_q;
   uef_byte_t rdata_q;
   // Event flags kept here; token done lives in the status queue, the error summary comes from the error flags
   logic stall_q;
   logic idle_q;
   logic act_q;
   logic brst_q;

   // Submodule results
   uef_byte_t err_flags;
   uef_byte_t err_en;
   logic err_summary;
   uef_byte_t xstat;
   logic tok_done;
   logic q_overflow;
   logic tok_clear;

   // Assembled views
   uef_byte_t evt_flags;
   uef_byte_t evt_pending;
   uef_byte_t evt_gate;
   uef_byte_t irq_events;
   uef_byte_t rd_mux;

   // Address decode for one-cycle write and read strobes
   // Decodes are combinational, so a strobe acts in the cycle it is sampled;
   // nothing waits, and unmapped addresses decode to nothing, so such writes are lost
   assign wr_evt_flags = reg_wr && (reg_addr == `UEF_OFS_EVT_FLAGS);
   assign wr_evt_en = reg_wr && (reg_addr == `UEF_OFS_EVT_EN);
   assign wr_err_flags = reg_wr && (reg_addr == `UEF_OFS_ERR_FLAGS);
   assign wr_err_en = reg_wr && (reg_addr == `UEF_OFS_ERR_EN);
   assign wr_ctrl = reg_wr && (reg_addr == `UEF_OFS_CTRL);
   assign wr_irq_mask = reg_wr && (reg_addr == `UEF_OFS_IRQ_MASK);
   assign rd_irq_stat = reg_rd && (reg_addr == `UEF_OFS_IRQ_STAT);

   // A zero written to the token done bit while it is set pops the queue
   // Writing a one keeps the flag, so only a written zero counts; the queue
   // ignores a clear while the flag is down and honours one beside a completion
   assign tok_clear = wr_evt_flags && !reg_wdata[`UEF_BIT_TOKDN]; // [RULE14]

   // Error flag register, enables and summary
   // Flags set on detection rather than at token end, so an error may be seen
   // before the token that caused it has finished
   // Enables read back exactly as written
   uef_err_flags u_err (
      .core_clk(core_clk),
      .rstn(rstn),
      .err_detect(err_detect),
      .flags_wr(wr_err_flags),
      .en_wr(wr_err_en),
      .wdata(reg_wdata),
      .err_flags(err_flags),
      .err_en(err_en),
      .err_summary(err_summary)
   );

   // Transaction status queue owns the token done flag
   // One entry is visible and three wait behind it; a completion that finds
   // all of them full is dropped and reported as an overflow
   // Overflow drops the newest status and keeps the older ones in order
   uef_stat_queue u_queue (
      .core_clk(core_clk),
      .rstn(rstn),
      .push(bd_done),
      .push_data(bd_status),
      .clear_req(tok_clear),
      .stat(xstat),
      .tok_done(tok_done),
      .overflow(q_overflow)
   );

   // Stall event flag: event sets, written zero clears, set wins
   // Set wins over a written zero, so an event arriving between the read of
   // the flags and their clear is never lost
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         stall_q <= 1'b0;
      end else if (evt_stall) begin
         stall_q <= 1'b1;
      end else if (wr_evt_flags && !reg_wdata[`UEF_BIT_STALL]) begin
         stall_q <= 1'b0; // [RULE16]
      end
   end

   // Bus idle event flag
   // Usually answered by setting the suspend control
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         idle_q <= 1'b0;
      end else if (evt_idle) begin
         idle_q <= 1'b1;
      end else if (wr_evt_flags && !reg_wdata[`UEF_BIT_IDLE]) begin
         idle_q <= 1'b0; // [RULE16]
      end
   end

   // Bus activity event flag
   // The only flag that can still interrupt while suspended
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         act_q <= 1'b0;
      end else if (evt_activity) begin
         act_q <= 1'b1;
      end else if (wr_evt_flags && !reg_wdata[`UEF_BIT_ACT]) begin
         act_q <= 1'b0; // [RULE16]
      end
   end

   // Bus reset event flag
   // Answered by returning the function to its default address and endpoint
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         brst_q <= 1'b0;
      end else if (evt_bus_reset) begin
         brst_q <= 1'b1;
      end else if (wr_evt_flags && !reg_wdata[`UEF_BIT_BRST]) begin
         brst_q <= 1'b0; // [RULE16]
      end
   end

   // Event enable register, bits 7..6 read as zero
   // Enables only gate the request; flags still set and can be polled
   // Writes of ones to bits 7..6 are dropped
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         evt_en_q <= `UEF_RST_EVT_EN;
      end else if (wr_evt_en) begin
         evt_en_q <= reg_wdata & `UEF_EVT_MASK; // [RULE1]
      end
   end

   // Control register: only the suspend bit is held here
   // The other control bits belong to the serial engine and read as zero;
   // writes to them are dropped
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= `UEF_RST_CTRL;
      end else if (wr_ctrl) begin
         ctrl_q <= reg_wdata & (8'h01 << `UEF_BIT_SUSPEND);
      end
   end

   // Suspend goes out so the serial engine can stop its own activity
   // The bit sits in control register bit 1
   assign suspend_ctrl = ctrl_q[`UEF_BIT_SUSPEND];

   // Event flag register view; error summary is live from the error flags
   // The summary is not stored: clearing the error flags or their enables
   // drops it with no write to this register; bits 7..6 read as zero
   always_comb begin
      evt_flags = `UEF_RST_BYTE;
      evt_flags[`UEF_BIT_STALL] = stall_q;
      evt_flags[`UEF_BIT_IDLE] = idle_q;
      evt_flags[`UEF_BIT_TOKDN] = tok_done; // [RULE17]
      evt_flags[`UEF_BIT_ACT] = act_q;
      evt_flags[`UEF_BIT_ERRSUM] = err_summary; // [RULE4]
      evt_flags[`UEF_BIT_BRST] = brst_q;
   end

   // Suspend leaves only the activity enable in force
   // The activity enable must be set before suspend is entered, or nothing
   // can wake the core; other flags still set and are seen once suspend ends
   always_comb begin
      evt_gate = evt_en_q; // [RULE1] [RULE2]
      if (suspend_ctrl) begin
         evt_gate = evt_en_q & (8'h01 << `UEF_BIT_ACT); // [RULE3]
      end
   end

   // Each flag qualified by its enable, all ORed into the core request
   // Level request: high until every enabled flag is cleared
   // Each enable is a plain AND; there is no edge detection or latching
   assign evt_pending = evt_flags & evt_gate; // [RULE2]
   assign usb_irq = |evt_pending; // [RULE16]

   // Block events for the sticky interrupt status register
   // Any error detect counts here, enabled or not; overflow only when a
   // completion is really dropped
   always_comb begin
      irq_events = `UEF_RST_BYTE;
      irq_events[`UEF_IRQ_PUSH] = bd_done;
      irq_events[`UEF_IRQ_OVFL] = q_overflow;
      irq_events[`UEF_IRQ_ERR] = |err_detect;
   end

   // Sticky status: a read clears it, a new event in that cycle stays set
   // Set wins over the clearing read, so an event in the read cycle shows
   // in the next read instead of being lost
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_q <= `UEF_RST_BYTE;
      end else if (rd_irq_stat) begin
         irq_stat_q <= irq_events;
      end else begin
         irq_stat_q <= irq_stat_q | irq_events;
      end
   end

   // Mask register for the block interrupt
   // Only bits 2..0 exist; the rest read as zero
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_mask_q <= `UEF_RST_BYTE;
      end else if (wr_irq_mask) begin
         irq_mask_q <= reg_wdata & `UEF_IRQ_MASK_BITS;
      end
   end

   // Level output, high while an unmasked status bit is set
   // Status and mask are both registers, so decode glitches never reach it
   assign blk_irq = |(irq_stat_q & irq_mask_q);

   // Read multiplexer; unmapped addresses read zero
   // Reading has no side effect except on the block status register
   // The default branch covers every unmapped address
   always_comb begin
      case (reg_addr)
         `UEF_OFS_EVT_FLAGS: rd_mux = evt_flags;
         `UEF_OFS_EVT_EN: rd_mux = evt_en_q;
         `UEF_OFS_ERR_FLAGS: rd_mux = err_flags;
         `UEF_OFS_ERR_EN: rd_mux = err_en;
         `UEF_OFS_XSTAT: rd_mux = xstat; // [RULE10]
         `UEF_OFS_CTRL: rd_mux = ctrl_q;
         `UEF_OFS_IRQ_STAT: rd_mux = irq_stat_q;
         `UEF_OFS_IRQ_MASK: rd_mux = irq_mask_q;
         default: rd_mux = `UEF_RST_BYTE;
      endcase
   end

   // Read data stands for the one cycle after the strobe only
   // Zero outside the answer cycle, so a stale value is never taken for
   // a fresh one
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= `UEF_RST_BYTE;
      end else if (reg_rd) begin
         rdata_q <= rd_mux; // [RULE9]
      end else begin
         rdata_q <= `UEF_RST_BYTE;
      end
   end

   // Registered read data to the bus
   assign reg_rdata = rdata_q;
endmodule : uef_top

/* File: tb/uef_sie_model.sv */
// Serial engine stand-in: event pulses, error detects and descriptor pushes.
// Assumes the bench calls its tasks; every signal changes right after a rising edge.
`timescale 1ns/1ps

module uef_sie_model (
   input wire logic core_clk,
   output logic evt_stall,
   output logic evt_idle,
   output logic evt_activity,
   output logic evt_bus_reset,
   output uef_pkg::uef_byte_t err_detect,
   output logic bd_done,
   output uef_pkg::uef_byte_t bd_status
);
   import uef_pkg::*;
   // Quiet at time zero
   initial begin
      {evt_stall, evt_idle, evt_activity, evt_bus_reset, bd_done} = 5'h00;
      err_detect = 8'h00;
      bd_status = 8'h5A;
   end

   // One-cycle event and error pulse, event bits in flag register layout
   task automatic fire(input logic [5:0] ev, input uef_byte_t er);
      @(posedge core_clk);
      {evt_stall, evt_idle, evt_activity, evt_bus_reset} <= {ev[5], ev[4], ev[2], ev[0]};
      err_detect <= er;
      @(posedge core_clk);
      {evt_stall, evt_idle, evt_activity, evt_bus_reset} <= 4'h0;
      err_detect <= 8'h00;
      #1;
   endtask : fire

   // Back-to-back descriptor completions with rising status bytes
   task automatic push(input uef_byte_t base, input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge core_clk);
         bd_done <= 1'b1;
         bd_status <= base + 8'(k);
      end
      @(posedge core_clk);
      bd_done <= 1'b0;
      bd_status <= ~bd_status; // Status no longer held once done drops
      #1;
   endtask : push
endmodule : uef_sie_model

/* File: tb/uef_top_chk.sv */
// Port-level assertions for the event flag block.
// Assumes register writes take effect at the edge that samples reg_wr.
`timescale 1ns/1ps
`include "uef_params.svh"

module uef_top_chk (
   input wire logic core_clk,
   input wire logic rstn,
   input wire uef_pkg::uef_addr_t reg_addr,
   input wire uef_pkg::uef_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire uef_pkg::uef_byte_t reg_rdata,
   input wire logic evt_stall,
   input wire logic evt_activity,
   input wire uef_pkg::uef_byte_t err_detect,
   input wire logic bd_done,
   input wire logic suspend_ctrl,
   input wire logic usb_irq,
   input wire logic blk_irq
);
   import uef_pkg::*;
   uef_byte_t en_q;
   uef_byte_t err_en_q;
   uef_byte_t mask_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // Shadow copies of enables and mask
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         en_q <= 8'h00;
         err_en_q <= 8'h00;
         mask_q <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == `UEF_OFS_EVT_EN) en_q <= reg_wdata & `UEF_EVT_MASK;
         if (reg_addr == `UEF_OFS_ERR_EN) err_en_q <= reg_wdata;
         if (reg_addr == `UEF_OFS_IRQ_MASK) mask_q <= reg_wdata & `UEF_IRQ_MASK_BITS;
      end
   end

   sequence push_s;
      bd_done && en_q[3] && !suspend_ctrl && !reg_wr;
   endsequence
   sequence rd_en_s;
      reg_rd && reg_addr == `UEF_OFS_EVT_EN;
   endsequence

   en_readback_a: assert property (rd_en_s |=> reg_rdata == en_q)
      else $error("event enable readback wrong");
   stall_irq_a: assert property (evt_stall && en_q[5] && !suspend_ctrl && !reg_wr |=> usb_irq)
      else $error("stall did not raise interrupt");
   err_irq_a: assert property ((|(err_detect & err_en_q)) && en_q[1] && !suspend_ctrl && !reg_wr |=> usb_irq)
      else $error("enabled error did not raise interrupt");
   suspend_gate_a: assert property (usb_irq && suspend_ctrl |-> en_q[2])
      else $error("interrupt during suspend without activity enable");
   wake_irq_a: assert property (evt_activity && en_q[2] && !reg_wr |=> usb_irq)
      else $error("activity did not raise interrupt");
   tok_irq_a: assert property (push_s |=> usb_irq)
      else $error("token done did not raise interrupt");
   rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   blk_err_a: assert property ((|err_detect) && mask_q[2] && !reg_wr |=> blk_irq)
      else $error("error detect did not raise block interrupt");
endmodule : uef_top_chk

bind uef_top uef_top_chk chk_u (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .evt_stall, .evt_activity, .err_detect, .bd_done, .suspend_ctrl, .usb_irq, .blk_irq);

/* File: tb/test_usb_event_flags_status_queue.sv */
// Self-checking bench for the event flag block: register tasks and scenarios.
// Assumes the serial engine model drives all event inputs.
`timescale 1ns/1ps
`include "uef_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module test_usb_event_flags_status_queue;
   import uef_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   uef_addr_t reg_addr = 9'h000;
   uef_byte_t reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   uef_byte_t reg_rdata, err_detect, bd_status, m;
   logic evt_stall, evt_idle, evt_activity, evt_bus_reset, bd_done;
   logic suspend_ctrl, usb_irq, blk_irq;
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   int bits[4] = '{5, 4, 2, 0};

   uef_top dut_u (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .evt_stall,
      .evt_idle, .evt_activity, .evt_bus_reset, .err_detect, .bd_done, .bd_status, .suspend_ctrl,
      .usb_irq, .blk_irq);
   uef_sie_model sie_u (.core_clk, .evt_stall, .evt_idle, .evt_activity, .evt_bus_reset,
      .err_detect, .bd_done, .bd_status);

   // 40 MHz clock
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors++;
         summarize();
      end
   end

   task automatic wr(input uef_addr_t a, input uef_byte_t d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input uef_addr_t a, input uef_byte_t e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask : rd

   task summarize;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      // Reset values and an unmapped place
      rd(`UEF_OFS_EVT_EN, 8'h00);
      rd(`UEF_OFS_ERR_EN, 8'h00);
      rd(`UEF_OFS_XSTAT, 8'h00);
      wr(9'h1A0, 8'hFF);
      rd(9'h1A0, 8'h00);
      // Each event gated by its own enable only
      for (int i = 0; i < 4; i++) begin
         m = 8'h01 << bits[i];
         wr(`UEF_OFS_EVT_EN, ~m & 8'h3F);
         sie_u.fire(m[5:0], 8'h00);
         `CHK(usb_irq, 1'b0)
         rd(`UEF_OFS_EVT_FLAGS, m);
         wr(`UEF_OFS_EVT_EN, m);
         `CHK(usb_irq, 1'b1)
         wr(`UEF_OFS_EVT_FLAGS, ~m);
         `CHK(usb_irq, 1'b0)
         sie_u.fire(m[5:0], 8'h00);
         `CHK(usb_irq, 1'b1)
         wr(`UEF_OFS_EVT_FLAGS, ~m);
      end
      // Each error bit gated by its own enable into the summary
      wr(`UEF_OFS_IRQ_MASK, 8'h04);
      wr(`UEF_OFS_EVT_EN, 8'h02);
      for (int i = 0; i < 8; i++) begin
         m = 8'h01 << i;
         wr(`UEF_OFS_ERR_EN, m);
         rd(`UEF_OFS_ERR_EN, m);
         sie_u.fire(6'h00, ~m);
         rd(`UEF_OFS_EVT_FLAGS, 8'h00);
         rd(`UEF_OFS_ERR_FLAGS, ~m);
         sie_u.fire(6'h00, m);
         rd(`UEF_OFS_EVT_FLAGS, 8'h02);
         `CHK(usb_irq, 1'b1)
         wr(`UEF_OFS_EVT_EN, 8'h00);
         `CHK(usb_irq, 1'b0)
         wr(`UEF_OFS_EVT_EN, 8'h02);
         `CHK(blk_irq, 1'b1)
         rd(`UEF_OFS_IRQ_STAT, 8'h04);
         `CHK(blk_irq, 1'b0)
         wr(`UEF_OFS_ERR_FLAGS, 8'hFF);
         rd(`UEF_OFS_ERR_FLAGS, 8'hFF);
         wr(`UEF_OFS_ERR_FLAGS, 8'h00);
         rd(`UEF_OFS_EVT_FLAGS, 8'h00);
      end
      // Suspend lets only activity through
      wr(`UEF_OFS_CTRL, 8'h02);
      `CHK(suspend_ctrl, 1'b1)
      rd(`UEF_OFS_CTRL, 8'h02);
      wr(`UEF_OFS_EVT_EN, 8'hFF);
      rd(`UEF_OFS_EVT_EN, 8'h3F);
      sie_u.fire(6'h31, 8'h00);
      `CHK(usb_irq, 1'b0)
      rd(`UEF_OFS_EVT_FLAGS, 8'h31);
      sie_u.fire(6'h04, 8'h00);
      `CHK(usb_irq, 1'b1)
      wr(`UEF_OFS_EVT_FLAGS, 8'h00);
      wr(`UEF_OFS_CTRL, 8'h00);
      `CHK(suspend_ctrl, 1'b0)
      // Five completions into a four-entry queue, drained in order
      wr(`UEF_OFS_EVT_EN, 8'h08);
      wr(`UEF_OFS_IRQ_MASK, 8'h03);
      sie_u.push(8'hA0, 5);
      `CHK(usb_irq, 1'b1)
      `CHK(blk_irq, 1'b1)
      rd(`UEF_OFS_IRQ_STAT, 8'h03);
      for (int k = 0; k < 4; k++) begin
         rd(`UEF_OFS_XSTAT, 8'hA0 + 8'(k));
         rd(`UEF_OFS_EVT_FLAGS, 8'h08);
         wr(`UEF_OFS_EVT_FLAGS, 8'hF7);
      end
      rd(`UEF_OFS_XSTAT, 8'h00);
      rd(`UEF_OFS_EVT_FLAGS, 8'h00);
      `CHK(usb_irq, 1'b0)
      // Reset in mid-run clears the registers and empties the queue
      sie_u.push(8'hB0, 2);
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      rd(`UEF_OFS_EVT_EN, 8'h00);
      rd(`UEF_OFS_EVT_FLAGS, 8'h00);
      `CHK(usb_irq, 1'b0)
      // A clear beside a completion: the new status becomes visible
      wr(`UEF_OFS_EVT_EN, 8'h08);
      sie_u.push(8'hC0, 1);
      fork
         wr(`UEF_OFS_EVT_FLAGS, 8'hF7);
         sie_u.push(8'hD0, 1);
      join
      rd(`UEF_OFS_XSTAT, 8'hD0);
      rd(`UEF_OFS_EVT_FLAGS, 8'h08);
      wr(`UEF_OFS_EVT_FLAGS, 8'hF7);
      rd(`UEF_OFS_XSTAT, 8'h00);
      summarize();
   end
endmodule : test_usb_event_flags_status_queue
